// >>> adcc_pkg.sv
// Package of constants for the converter control block
package adcc_pkg;
  // ************************************************************
  // Widths and field positions
  // ************************************************************
  localparam int RES_W     = 10;        // Result width
  localparam int CH_W      = 4;         // Channel select width
  localparam int EOC_BIT   = 7;         // Flag bit in status byte
  localparam int SPEED_BIT = 6;
  localparam int ON_BIT    = 5;
  localparam int SLOW_BIT  = 4;
  // ************************************************************
  // Values after reset and saturation codes
  // ************************************************************
  localparam logic [7:0] CSR_RESET  = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [7:0] LOW_RESET  = 8'h00;
  localparam logic [7:0] SAT_HIGH   = 8'hFF;  // Over upper reference
  localparam logic [7:0] SAT_LOW    = 8'h03;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;  // Under lower reference
  // ************************************************************
  // Times in ns and counts of cycles
  // ************************************************************
  localparam int STAB_NS     = 4000;          // Settling after halt, ns
  localparam int CLK_NS      = 4;             // Clock period, ns
  localparam int STAB_CYCLES = (STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAR_STEPS   = 10;            // One step per result bit
  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    ADCC_OFF    = 4'b0001,
    ADCC_SETTLE = 4'b0010,
    ADCC_SAMPLE = 4'b0100,
    ADCC_CONV   = 4'b1000
  } adcc_state_t;
endpackage : adcc_pkg

// >>> adcc_clkdiv.sv
// Converter clock tick generator from the two clock-select bits
module adcc_clkdiv (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Select bits
  input  wire logic slow,
  input  wire logic speed,
  // Converter clock tick
  output logic      tick
);
  import adcc_pkg::*;

  logic [1:0] cnt_reg;   // Prescaler count
  logic [1:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;

  // ************************************************************
  // Divide ratio selection
  // ************************************************************
  // Next count and tick; both-set reads the same as /2
  always_comb begin
    cnt_next  = cnt_reg + 2'h1;
    tick_next = 1'b0;
    if (!slow && speed) begin       // Full CPU clock
      cnt_next  = 2'h0;
      tick_next = 1'b1;
    end else if (slow && !speed) begin  // Divide by four
      tick_next = (cnt_reg == 2'h3);
    end else begin                  // Divide by two
      tick_next = cnt_reg[0];
      cnt_next  = {1'b0, ~cnt_reg[0]};
    end
  end

  // Register the divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule // adcc_clkdiv

// >>> adcc_core.sv
// Control of a 10-bit successive approximation converter
// What this block does
// (R1) Converter on starts continuous conversions
// (R2) Each completion sets flag, loads result if unlocked
// (R3) High byte read clears complete flag
// (R4) Over upper reference saturates to FFh/03h
// (R5) Under lower reference gives zero result
// (R6) Channel change restarts, clears flag
// (R7) Low byte read locks both bytes
// (R8) High read or converter off unlocks
// (R9) Locked result bytes take no update
// (R10) Software: poll, read low, read high
// (R11) Software: poll, read high for 8 bits
// (R12) Converter off stops conversion
// (R13) Wait mode leaves converter unchanged
// (R14) Halt disables; settle time after wake
// (R15) Ten-bit result, sixteen channel mux
// (R16) No interrupt; completion only polled
// (R17) Status write clears flag; flag read-only
// (R18) Channel field binary selects input
// (R19) High byte bits 9:2, low bits 1:0
// (R20) Two select bits set converter clock
module adcc_core #(
  parameter int STAB_CNT = adcc_pkg::STAB_CYCLES   // Settle cycles after halt
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Status register access from the CPU
  input  wire logic                     csr_wr,        // Write strobe, one cycle
  input  wire logic [7:0]               csr_wdata,
  input  wire logic                     high_rd,       // Read strobe of high byte
  input  wire logic                     low_rd,        // Read strobe of low byte
  output logic      [7:0]               conv_ctrl_status_reg,
  output logic      [7:0]               result_high_byte_reg,
  output logic      [7:0]               result_low_byte_reg,
  // Power modes
  input  wire logic                     cpu_wait,      // Ignored on purpose
  input  wire logic                     cpu_halt,
  output logic                          stab_done,     // Results trusted again
  // Analog front end
  output logic      [adcc_pkg::CH_W-1:0] channel_select,
  output logic                          analog_enable,
  output logic                          sample_hold,
  output logic      [adcc_pkg::RES_W-1:0] dac_code,    // Trial code to comparator
  input  wire logic                     comp_in,       // Comparator, asynchronous
  input  wire logic                     over_range_in, // Above upper reference
  input  wire logic                     under_range_in // Below lower reference
);
  import adcc_pkg::*;

  // ************************************************************
  // Control bits and synchronisers
  // ************************************************************
  logic [7:0]       csr_reg, csr_next;         // Status/control byte
  logic [7:0]       high_reg, high_next;       // Result bits 9:2
  logic [7:0]       low_reg, low_next;         // Result bits 1:0
  logic             lock_reg, lock_next;       // Result lock
  logic [2:0]       s1_reg, s2_reg;            // Comparator and range syncs
  adcc_state_t      state_reg, state_next;
  logic [RES_W-1:0] sar_reg, sar_next;         // Approximation register
  logic [3:0]       step_reg, step_next;       // Bit being tried
  logic [31:0]      stab_reg, stab_next;       // Settle countdown
  logic [1:0]       age_reg, age_next;         // Clocks since the trial code moved
  logic [RES_W-1:0] dac_reg, dac_next;         // Registered trial code
  logic             stab_done_reg, stab_done_next; // Registered settle flag
  logic             step_go;                   // Comparator answer is settled
  logic             ana_reg, ana_next;
  logic             sh_reg, sh_next;
  logic             tick;
  logic             conv_on;
  logic             chan_change;
  logic             done;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] result;

  // Converter clock prescaler
  adcc_clkdiv adcc_clkdiv_inst (
    .clk   (clk),
    .rst   (rst),
    .slow  (csr_reg[SLOW_BIT]),
    .speed (csr_reg[SPEED_BIT]),
    .tick  (tick)                               // [R20]
  );

  // Two-stage synchronisers; first stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
    end else begin
      s1_reg <= {under_range_in, over_range_in, comp_in};
      s2_reg <= s1_reg;
    end
  end

  // Halt gates the converter; wait is deliberately not looked at
  assign conv_on     = csr_reg[ON_BIT] && !cpu_halt;           // [R12] [R14] [R13]
  assign chan_change = csr_wr && (csr_wdata[CH_W-1:0] != csr_reg[CH_W-1:0]);
  assign trial       = sar_reg | (RES_W'(1) << step_reg);
  // Comparator crosses two flops; a decision waits two clocks after the code moves
  assign step_go     = tick && age_reg[1];
  assign done        = (state_reg == ADCC_CONV) && step_go && (step_reg == 4'h0);

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  // One sample phase, then one bit per step_go (a tick at least two clocks after the code moves), MSB first
  always_comb begin
    state_next = state_reg;
    sar_next   = sar_reg;
    step_next  = step_reg;
    stab_next  = stab_reg;
    ana_next   = conv_on;
    sh_next    = 1'b0;
    age_next   = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;  // Saturating age
    unique case (state_reg)
      ADCC_OFF: begin
        if (conv_on) begin                      // [R1]
          state_next = ADCC_SETTLE;
          stab_next  = 32'(STAB_CNT);
        end
      end
      ADCC_SETTLE: begin
        // Settle countdown; conversions run meanwhile are flagged untrusted
        state_next = ADCC_SAMPLE;
      end
      ADCC_SAMPLE: begin
        sh_next = 1'b1;
        if (tick) begin
          state_next = ADCC_CONV;
          sar_next   = '0;
          step_next  = 4'(SAR_STEPS - 1);
          age_next   = 2'h0;                    // First trial code goes out
        end
      end
      ADCC_CONV: begin
        if (step_go) begin
          age_next = 2'h0;                      // Next trial code goes out
          if (s2_reg[0])                        // Keep bit if input above trial
            sar_next = trial;
          if (step_reg == 4'h0)
            state_next = ADCC_SAMPLE;           // Continuous mode [R1]
          else
            step_next = step_reg - 4'h1;
        end
      end
    endcase
    if (stab_reg != 32'h0 && conv_on)
      stab_next = stab_reg - 32'h1;             // [R14]
    if (!conv_on) begin                         // [R12]
      state_next = ADCC_OFF;
      ana_next   = 1'b0;
    end else if (chan_change) begin             // Abort and restart [R6]
      state_next = ADCC_SAMPLE;
    end
    // Registered copies of the trial code and the settle flag
    dac_next       = sar_next | (RES_W'(1) << step_next);
    stab_done_next = (stab_next == 32'h0);      // [R14]
  end

  // Register the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ADCC_OFF;
      sar_reg   <= '0;
      step_reg  <= 4'h0;
      stab_reg  <= 32'h0;
      ana_reg   <= 1'b0;
      sh_reg    <= 1'b0;
      age_reg   <= 2'h0;
      dac_reg   <= '0;
      stab_done_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      sar_reg   <= sar_next;
      step_reg  <= step_next;
      stab_reg  <= stab_next;
      ana_reg   <= ana_next;
      sh_reg    <= sh_next;
      age_reg   <= age_next;
      dac_reg   <= dac_next;
      stab_done_reg <= stab_done_next;
    end
  end

  // ************************************************************
  // Result, flag and lock
  // ************************************************************
  // Final bit folded in here; range detectors override the code
  always_comb begin
    result = s2_reg[0] ? trial : sar_reg;
    if (s2_reg[1])
      result = {SAT_HIGH, SAT_LOW[1:0]};        // [R4]
    else if (s2_reg[2])
      result = {ZERO_BYTE, ZERO_BYTE[1:0]};     // [R5]
  end

  // Registers, flag and lock next values
  always_comb begin
    csr_next  = csr_reg;
    high_next = high_reg;
    low_next  = low_reg;
    lock_next = lock_reg;
    if (csr_wr) begin
      csr_next[6:0]   = csr_wdata[6:0];         // Flag bit not writable [R17]
      csr_next[EOC_BIT] = 1'b0;                 // [R17]
    end
    if (high_rd)
      csr_next[EOC_BIT] = 1'b0;                 // [R3]
    if (low_rd)
      lock_next = 1'b1;                         // [R7]
    if (high_rd || !csr_next[ON_BIT])
      lock_next = 1'b0;                         // [R8]
    if (chan_change)
      csr_next[EOC_BIT] = 1'b0;                 // [R6]
    else if (done && conv_on) begin
      csr_next[EOC_BIT] = 1'b1;                 // Set beats a read clear [R2]
      if (!lock_next) begin                     // Low read now freezes the old pair [R7] [R9]
        high_next = result[RES_W-1:2];          // [R19] [R2]
        low_next  = {6'h00, result[1:0]};       // [R19]
      end
    end
  end

  // Register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csr_reg  <= CSR_RESET;
      high_reg <= HIGH_RESET;
      low_reg  <= LOW_RESET;
      lock_reg <= 1'b0;
    end else begin
      csr_reg  <= csr_next;
      high_reg <= high_next;
      low_reg  <= low_next;
      lock_reg <= lock_next;
    end
  end

  // Outputs; channel code drives the mux straight [R18] [R15]
  assign conv_ctrl_status_reg = csr_reg;
  assign result_high_byte_reg = high_reg;
  assign result_low_byte_reg  = low_reg;
  assign channel_select       = csr_reg[CH_W-1:0];
  assign analog_enable        = ana_reg;
  assign sample_hold          = sh_reg;
  assign dac_code             = dac_reg;
  assign stab_done            = stab_done_reg;   // No interrupt output [R16]
endmodule // adcc_core

// >>> adcc_assertions.sv
// Port assertions for the converter control block
module adcc_assertions #(
  parameter int STAB_CNT = adcc_pkg::STAB_CYCLES  // Same as the core
) (
  // CPU side
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       csr_wr,
  input wire logic [7:0] csr_wdata,
  input wire logic       high_rd,
  input wire logic       low_rd,
  input wire logic [7:0] conv_ctrl_status_reg,
  input wire logic [7:0] result_high_byte_reg,
  input wire logic [7:0] result_low_byte_reg,
  // Power and analog side
  input wire logic       cpu_halt,
  input wire logic       analog_enable,
  input wire logic [adcc_pkg::CH_W-1:0] channel_select
);
  timeunit 1ns;
  timeprecision 1ps;
  import adcc_pkg::*;
  // ***
  // Shorthands
  // ***
  logic eoc;      // Complete flag
  logic conv_on;  // Converter on bit
  assign eoc     = conv_ctrl_status_reg[EOC_BIT];
  assign conv_on = conv_ctrl_status_reg[ON_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_pad; result_low_byte_reg[7:2] == 6'h00; endproperty
  a_pad: assert property (p_pad) else $error("low pad set");
  property p_wr; csr_wr |=> conv_ctrl_status_reg[6:0] == $past(csr_wdata[6:0]); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_chg; csr_wr && csr_wdata[3:0] != conv_ctrl_status_reg[3:0] |=> !eoc; endproperty
  a_chg: assert property (p_chg) else $error("flag kept");
  property p_upd; $changed(result_high_byte_reg) || $changed(result_low_byte_reg) |-> eoc; endproperty
  a_upd: assert property (p_upd) else $error("silent update");
  // Lock holds both bytes until high read or converter off
  property p_lock; low_rd && !high_rd |=> ($stable(result_high_byte_reg)
    && $stable(result_low_byte_reg)) until (high_rd || !conv_on); endproperty
  a_lock: assert property (p_lock) else $error("locked bytes moved");
  property p_off; (!conv_on || cpu_halt) [*2] |-> !analog_enable; endproperty
  a_off: assert property (p_off) else $error("converter not off");
  property p_on; $rose(conv_on) && !cpu_halt |-> ##[0:2] analog_enable; endproperty
  a_on: assert property (p_on) else $error("converter not on");
  property p_chan; $stable(conv_ctrl_status_reg[3:0]) [*3] |-> channel_select == conv_ctrl_status_reg[3:0]; endproperty
  a_chan: assert property (p_chan) else $error("wrong input");
endmodule // adcc_assertions

bind adcc_core adcc_assertions #(.STAB_CNT(STAB_CNT)) adcc_assertions_inst (.clk, .rst, .csr_wr, .csr_wdata,
  .high_rd, .low_rd, .conv_ctrl_status_reg, .result_high_byte_reg, .result_low_byte_reg, .cpu_halt,
  .analog_enable, .channel_select);

// >>> adcc_afe_model.sv
// Behavioural sixteen-input analog front end
module adcc_afe_model (
  // From the core
  input wire logic                       clk,
  input wire logic [adcc_pkg::CH_W-1:0]  channel_select,
  input wire logic                       analog_enable,
  input wire logic                       sample_hold,
  input wire logic [adcc_pkg::RES_W-1:0] dac_code,
  // To the core
  output logic                           comp_in,
  output logic                           over_range_in,
  output logic                           under_range_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int   lvl [16] = '{default: 0};  // Input levels in codes
  int   held     = 0;              // Held sample
  logic tog      = 1'b0;           // Junk while powered down
  // Track the selected input while sampling
  always @(posedge clk) begin
    tog <= ~tog;
    if (sample_hold && analog_enable) held <= lvl[channel_select];
  end
  // Half a code of offset keeps decisions off the trial point
  always_comb begin
    comp_in        = analog_enable ? (2 * held + 1 > 2 * int'(dac_code)) : tog;
    over_range_in  = held > 1023;
    under_range_in = held < 0;
  end
endmodule // adcc_afe_model

// >>> test_adcc_core.sv
// Self-checking bench for the converter control block
module test_adcc_core;
  timeunit 1ns;
  timeprecision 1ps;
  import adcc_pkg::*;
  // ***
  // Signals and table
  // ***
  logic clk = 1'b0, rst = 1'b1, csr_wr = 1'b0, high_rd = 1'b0, low_rd = 1'b0;
  logic cpu_wait = 1'b0, cpu_halt = 1'b0, stab_done, analog_enable, sample_hold;
  logic comp_in, over_range_in, under_range_in;
  logic [7:0] csr_wdata = 8'h00, status, res_h, res_l, v_h, v_l;
  logic [CH_W-1:0] channel_select;
  logic [RES_W-1:0] dac_code;
  int fails = 0, num_checks = 0;
  logic [3:0] t_ch [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
  logic [1:0] t_ck [4] = '{2'h0, 2'h1, 2'h2, 2'h3};  // Speed, slow
  int t_lv [4] = '{677, 1100, -5, 341};  // Over, then under range
  logic [9:0] t_ex [4] = '{10'h2A5, 10'h3FF, 10'h000, 10'h155};
  adcc_core #(.STAB_CNT(4)) adcc_core_inst (.clk, .rst, .csr_wr, .csr_wdata, .high_rd, .low_rd,
    .conv_ctrl_status_reg(status), .result_high_byte_reg(res_h), .result_low_byte_reg(res_l),
    .cpu_wait, .cpu_halt, .stab_done, .channel_select, .analog_enable, .sample_hold, .dac_code,
    .comp_in, .over_range_in, .under_range_in);
  adcc_afe_model adcc_afe_model_inst (.clk, .channel_select, .analog_enable, .sample_hold,
    .dac_code, .comp_in, .over_range_in, .under_range_in);
  initial forever #2 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Status write, strobe up for one edge
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    csr_wdata <= d;
    csr_wr <= 1'b1;
    @(posedge clk);
    csr_wr <= 1'b0;
  endtask
  // Byte read; data is steady until the sampling edge
  task automatic rd(input bit hi, output logic [7:0] v);
    @(posedge clk);
    high_rd <= hi;
    low_rd <= !hi;
    #1 v = hi ? res_h : res_l;
    @(posedge clk);
    high_rd <= 1'b0;
    low_rd <= 1'b0;
  endtask
  // Bounded poll of the flag
  task automatic wait_eoc;
    for (int n = 0; n < 3000 && status[EOC_BIT] !== 1'b1; n++) @(posedge clk) #1;
    chk(status[EOC_BIT], 1'b1);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog far past the expected run
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  // ***
  // Tests
  // ***
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cpu_wait <= 1'b1;  // Kept up through the conversions
    #1 chk({status, res_h}, 16'h0000);
    chk({stab_done, res_l}, 16'h0100);
    $display("Test reset done");
    for (int i = 0; i < 4; i++) begin
      if (i > 0) wait_eoc();
      adcc_afe_model_inst.lvl[t_ch[i]] = t_lv[i];
      wr({1'b1, t_ck[i][1], 1'b1, t_ck[i][0], t_ch[i]});
      #1 chk(status, {1'b0, t_ck[i][1], 1'b1, t_ck[i][0], t_ch[i]});
      wait_eoc();
      rd(1'b0, v_l);
      rd(1'b1, v_h);
      chk({v_h, v_l}, {t_ex[i][9:2], 6'h00, t_ex[i][1:0]});
      #1 chk(status[EOC_BIT], 1'b0);
    end
    $display("Test conversions done");
    wait_eoc();
    rd(1'b0, v_l);
    adcc_afe_model_inst.lvl[15] = 200;
    repeat (300) @(posedge clk);
    rd(1'b1, v_h);
    chk({v_h, v_l}, 16'h5501);
    rd(1'b0, v_l); // Lock again; switching off must free it
    $display("Test lock done");
    wr(8'h0F);
    adcc_afe_model_inst.lvl[15] = 400;
    repeat (200) @(posedge clk);
    #1 chk({status, 7'h00, analog_enable}, 16'h0F00);
    @(posedge clk);
    cpu_halt <= 1'b1;
    cpu_wait <= 1'b0;
    wr(8'h6F);
    repeat (20) @(posedge clk);
    #1 chk(analog_enable, 1'b0);
    @(posedge clk);
    cpu_halt <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(stab_done, 1'b0);
    wait_eoc();
    chk(stab_done, 1'b1);
    rd(1'b1, v_h);
    chk(v_h, 8'h64);
    #1 chk(status[EOC_BIT], 1'b0);
    $display("Test power modes done");
    finish_test();
  end
endmodule // test_adcc_core
